// ==== verilog/rsc_pkg.sv ====
`default_nettype none

package rsc_pkg;

   // ********************************************************************
   // Bus and register file geometry
   // ********************************************************************
   localparam int RSC_ADDR_W   = 12;
   localparam int RSC_DATA_W   = 32;
   localparam int RSC_REG_W    = 8;
   localparam int RSC_IDX_W    = 7;
   localparam int RSC_IDX_LSB  = 2;
   localparam int RSC_IDX_MSB  = 8;
   localparam int RSC_NUM_REGS = 79;
   localparam int RSC_CNT_W    = 24;

   // ********************************************************************
   // Register indices (byte address is four times the index)
   // ********************************************************************
   localparam int RSC_IDX_PSW        = 0;
   localparam int RSC_IDX_PORT_LATCH = 1;
   localparam int RSC_IDX_PORT_DIR   = 10;
   localparam int RSC_IDX_PULLUP     = 19;
   localparam int RSC_IDX_CPU_CLK    = 21;
   localparam int RSC_IDX_OSC_MODE   = 22;
   localparam int RSC_IDX_MEM_SIZE   = 23;
   localparam int RSC_IDX_STAB_TIME  = 24;
   localparam int RSC_IDX_T16_COUNT  = 25;
   localparam int RSC_IDX_T16_CAPCTL = 29;
   localparam int RSC_IDX_T8_COUNT   = 31;
   localparam int RSC_IDX_WDT_MODE   = 38;
   localparam int RSC_IDX_SER_CLK    = 39;
   localparam int RSC_IDX_SER_MODE   = 41;
   localparam int RSC_IDX_TX_SHIFT   = 49;
   localparam int RSC_IDX_ADC_MODE   = 51;
   localparam int RSC_IDX_LCD        = 53;
   localparam int RSC_IDX_IRQ_REQ    = 55;
   localparam int RSC_IDX_IRQ_MASK   = 58;
   localparam int RSC_IDX_EXT_IRQ    = 64;
   localparam int RSC_IDX_KEY_RET    = 66;
   localparam int RSC_IDX_KEEP_FIRST = 68;
   localparam int RSC_IDX_STATUS     = 78;

   // ********************************************************************
   // Reset values and field positions
   // ********************************************************************
   localparam logic [7:0] RSC_RV_ZERO      = 8'h00;
   localparam logic [7:0] RSC_RV_ONES      = 8'hff;
   localparam logic [7:0] RSC_RV_PSW       = 8'h02;
   localparam logic [7:0] RSC_RV_CLK_STAB  = 8'h04;
   localparam logic [7:0] RSC_RV_SER_CLK   = 8'h88;
   localparam logic [7:0] RSC_RV_ADC_MODE  = 8'h01;
   localparam logic [7:0] RSC_RV_KEY_RET   = 8'h02;
   localparam logic [7:0] RSC_RV_MEM_SMALL = 8'hcc;
   localparam logic [7:0] RSC_RV_MEM_LARGE = 8'hcf;

   localparam int RSC_WDT_LOOP_BIT = 4;
   localparam int RSC_STAT_EXT_BIT = 0;
   localparam int RSC_STAT_WDT_BIT = 1;
   localparam int RSC_STAT_STOP_BIT = 2;

   localparam logic [15:0] RSC_VEC_LO_ADDR = 16'h0000;
   localparam logic [15:0] RSC_VEC_HI_ADDR = 16'h0001;

   // ********************************************************************
   // Timing: stabilization wait in main clock periods
   // ********************************************************************
   localparam int RSC_STAB_EXP     = 17;
   localparam int RSC_STAB_PERIODS = 2 ** RSC_STAB_EXP;
   localparam int RSC_CLK_PER_MAIN = 1;
   localparam int RSC_STAB_CYCLES  = RSC_STAB_PERIODS * RSC_CLK_PER_MAIN;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [2:0] {
      RSC_ST_HOLD     = 3'b000,
      RSC_ST_WAIT     = 3'b001,
      RSC_ST_FETCH_LO = 3'b011,
      RSC_ST_FETCH_HI = 3'b010,
      RSC_ST_LOAD     = 3'b110,
      RSC_ST_RUN      = 3'b111
   } rsc_state_e;

   typedef struct packed {
      logic [RSC_ADDR_W-1:0] paddr;
      logic                  psel;
      logic                  penable;
      logic                  pwrite;
      logic [RSC_DATA_W-1:0] pwdata;
      logic [3:0]            pstrb;
   } rsc_apb_req_s;

   typedef struct packed {
      logic [RSC_DATA_W-1:0] prdata;
      logic                  pready;
      logic                  pslverr;
   } rsc_apb_rsp_s;

   typedef struct packed {
      logic pins_hiz;
      logic main_osc_stop;
      logic sub_osc_run;
      logic periph_reset;
      logic ram_hold;
      logic stop_hold;
      logic cpu_run;
   } rsc_core_ctl_s;

   // Registers left undefined by reset, plus the status, are not reloaded
   function automatic logic rsc_keeps(input int idx);
      return idx >= RSC_IDX_KEEP_FIRST;
   endfunction

   function automatic logic [7:0] rsc_reset_value(input int   idx,
                                                  input logic big_rom);
      logic [7:0] v;
      v = RSC_RV_ZERO;
      if (idx == RSC_IDX_PSW) begin
         v = RSC_RV_PSW;
      end else if (idx >= RSC_IDX_PORT_DIR && idx < RSC_IDX_PULLUP) begin
         v = RSC_RV_ONES;
      end else if (idx == RSC_IDX_CPU_CLK || idx == RSC_IDX_STAB_TIME) begin
         v = RSC_RV_CLK_STAB;
      end else if (idx == RSC_IDX_MEM_SIZE) begin
         v = big_rom ? RSC_RV_MEM_LARGE : RSC_RV_MEM_SMALL;
      end else if (idx == RSC_IDX_T16_CAPCTL) begin
         v = RSC_RV_CLK_STAB;
      end else if (idx >= RSC_IDX_SER_CLK && idx < RSC_IDX_SER_MODE) begin
         v = RSC_RV_SER_CLK;
      end else if (idx == RSC_IDX_TX_SHIFT) begin
         v = RSC_RV_ONES;
      end else if (idx == RSC_IDX_ADC_MODE) begin
         v = RSC_RV_ADC_MODE;
      end else if (idx >= RSC_IDX_IRQ_MASK && idx < RSC_IDX_EXT_IRQ) begin
         v = RSC_RV_ONES;
      end else if (idx == RSC_IDX_KEY_RET) begin
         v = RSC_RV_KEY_RET;
      end
      return v;
   endfunction

endpackage

`default_nettype wire

// ==== verilog/rsc_reset_ctrl.sv ====
`default_nettype none

module rsc_reset_ctrl
   import rsc_pkg::*;
#(
   parameter int   STAB_CYCLES = RSC_STAB_CYCLES,
   parameter logic LARGE_ROM   = 1'b1
) (
   input  wire logic                            clk_sys_in,
   input  wire logic                            rst_in,
   input  wire logic                            ext_reset_n_in,
   input  wire logic                            watchdog_overflow_in,
   input  wire logic                            stop_mode_in,
   input  wire logic [7:0]                      vec_data_in,
   input  wire rsc_apb_req_s                    apb_req_in,
   output      rsc_apb_rsp_s                    apb_rsp_out,
   output      rsc_core_ctl_s                   core_ctl_out,
   output      logic [15:0]                     pc_out,
   output      logic                            pc_valid_out,
   output      logic [15:0]                     vec_addr_out,
   output      logic                            vec_rd_out,
   output      logic [RSC_NUM_REGS*RSC_REG_W-1:0] reg_image_out
);

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      logic                                  pin_meta;
      logic                                  pin_sync;
      rsc_state_e                            state;
      logic [RSC_CNT_W-1:0]                  cnt;
      logic [15:0]                           pc;
      logic                                  pc_valid;
      logic [15:0]                           vec_addr;
      logic                                  vec_rd;
      logic [RSC_NUM_REGS-1:0][RSC_REG_W-1:0] regs;
      rsc_apb_rsp_s                          rsp;
      rsc_core_ctl_s                         ctl;
   } rsc_ctrl_s;

   localparam logic [RSC_CNT_W-1:0] STAB_LAST =
      RSC_CNT_W'(STAB_CYCLES - 1);
   localparam logic [RSC_IDX_W-1:0] REG_COUNT = RSC_IDX_W'(RSC_NUM_REGS);
   localparam logic [RSC_IDX_W-1:0] STAT_IDX  = RSC_IDX_W'(RSC_IDX_STATUS);

   function automatic rsc_ctrl_s reset_state();
      rsc_ctrl_s s;
      s = '0;
      // Synchroniser starts at the idle pin level: no false cause logged
      s.pin_meta          = 1'b1;
      s.pin_sync          = 1'b1;
      s.state             = RSC_ST_HOLD;
      s.ctl.pins_hiz      = 1'b1;
      s.ctl.main_osc_stop = 1'b1;
      s.ctl.sub_osc_run   = 1'b1;
      s.ctl.periph_reset  = 1'b1;
      s.ctl.ram_hold      = 1'b1;
      for (int i = 0; i < RSC_NUM_REGS; i++) begin
         s.regs[i] = rsc_reset_value(i, LARGE_ROM);
      end
      return s;
   endfunction

   localparam rsc_ctrl_s RESET_Q = reset_state();

   rsc_ctrl_s             q;
   rsc_ctrl_s             next_q;
   logic                  ext_req;
   logic                  wdt_req;
   logic                  rst_req;
   logic [RSC_IDX_W-1:0]  idx;
   logic                  mapped;
   logic                  setup;
   logic                  access;

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      next_q = q;

      // Pin synchroniser
      next_q.pin_meta = ext_reset_n_in;
      next_q.pin_sync = q.pin_meta;

      ext_req = ~q.pin_sync;
      wdt_req = watchdog_overflow_in
                & q.regs[RSC_IDX_WDT_MODE][RSC_WDT_LOOP_BIT];
      rst_req = ext_req | wdt_req;

      idx    = apb_req_in.paddr[RSC_IDX_MSB:RSC_IDX_LSB];
      mapped = (apb_req_in.paddr[RSC_IDX_LSB-1:0] == '0)
               && (apb_req_in.paddr[RSC_ADDR_W-1:RSC_IDX_MSB+1] == '0)
               && (idx < REG_COUNT);
      setup  = apb_req_in.psel & ~apb_req_in.penable;
      access = apb_req_in.psel & apb_req_in.penable & q.rsp.pready;

      // Sequencer
      case (q.state)
         RSC_ST_HOLD: begin
            // Watchdog request is a pulse, so hold ends on its own
            if (!ext_req) begin
               next_q.state = RSC_ST_WAIT;
               next_q.cnt   = '0;
            end
         end
         RSC_ST_WAIT: begin
            if (q.cnt == STAB_LAST) begin
               next_q.state    = RSC_ST_FETCH_LO;
               next_q.vec_addr = RSC_VEC_LO_ADDR;
               next_q.vec_rd   = 1'b1;
            end else begin
               next_q.cnt = q.cnt + RSC_CNT_W'(1);
            end
         end
         RSC_ST_FETCH_LO: begin
            next_q.vec_addr = RSC_VEC_HI_ADDR;
            next_q.state    = RSC_ST_FETCH_HI;
         end
         RSC_ST_FETCH_HI: begin
            next_q.pc[7:0] = vec_data_in;
            next_q.vec_rd  = 1'b0;
            next_q.state   = RSC_ST_LOAD;
         end
         RSC_ST_LOAD: begin
            next_q.pc[15:8] = vec_data_in;
            next_q.pc_valid = 1'b1;
            next_q.state    = RSC_ST_RUN;
         end
         RSC_ST_RUN: begin
            next_q.state = RSC_ST_RUN;
         end
         default: begin
            next_q.state = RSC_ST_HOLD;
         end
      endcase

      // Bus slave: one wait-free access phase, read data sampled at setup, write data taken in the access phase
      next_q.rsp.pready  = setup;
      next_q.rsp.pslverr = 1'b0;
      next_q.rsp.prdata  = '0;
      if (setup) begin
         if (!mapped) begin
            next_q.rsp.pslverr = 1'b1;
         end else if (apb_req_in.pwrite
                      && (idx == STAT_IDX || q.state != RSC_ST_RUN)) begin
            // Status is read-only; no writes while reset values must stand
            next_q.rsp.pslverr = 1'b1;
         end else begin
            next_q.rsp.prdata = {{(RSC_DATA_W-RSC_REG_W){1'b0}},
                                 q.regs[idx]};
         end
      end
      if (access && apb_req_in.pwrite && mapped && idx != STAT_IDX
          && q.state == RSC_ST_RUN && !rst_req && apb_req_in.pstrb[0]) begin
         next_q.regs[idx] = apb_req_in.pwdata[RSC_REG_W-1:0];
      end

      // Any request restarts the whole sequence
      if (rst_req) begin
         next_q.state    = RSC_ST_HOLD;
         next_q.cnt      = '0;
         next_q.pc_valid = 1'b0;
         next_q.vec_rd   = 1'b0;
         if (q.state != RSC_ST_HOLD) begin
            next_q.regs[RSC_IDX_STATUS] = '0;
            next_q.ctl.stop_hold = stop_mode_in;
            next_q.regs[RSC_IDX_STATUS][RSC_STAT_STOP_BIT] = stop_mode_in;
         end
         if (ext_req) begin
            next_q.regs[RSC_IDX_STATUS][RSC_STAT_EXT_BIT] = 1'b1;
         end
         if (wdt_req) begin
            next_q.regs[RSC_IDX_STATUS][RSC_STAT_WDT_BIT] = 1'b1;
         end
      end

      // Reload of all defined reset values while reset is applied
      if (next_q.state == RSC_ST_HOLD) begin
         for (int i = 0; i < RSC_NUM_REGS; i++) begin
            if (!rsc_keeps(i)) begin
               next_q.regs[i] = rsc_reset_value(i, LARGE_ROM);
            end
         end
      end
      // Values above: ports clocks memory size
      // timers serial converter
      // display interrupts

      if (next_q.state != RSC_ST_HOLD) begin
         next_q.ctl.stop_hold = 1'b0;
      end

      // Core controls follow the next state so they line up with it
      next_q.ctl.pins_hiz      = (next_q.state != RSC_ST_RUN);
      next_q.ctl.main_osc_stop = (next_q.state == RSC_ST_HOLD);
      next_q.ctl.sub_osc_run   = 1'b1;
      next_q.ctl.periph_reset  = (next_q.state != RSC_ST_RUN);
      next_q.ctl.ram_hold      = (next_q.state != RSC_ST_RUN);
      next_q.ctl.cpu_run       = (next_q.state == RSC_ST_RUN);
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         q <= RESET_Q;
      end else begin
         q <= next_q;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign apb_rsp_out   = q.rsp;
   assign core_ctl_out  = q.ctl;
   assign pc_out        = q.pc;
   assign pc_valid_out  = q.pc_valid;
   assign vec_addr_out  = q.vec_addr;
   assign vec_rd_out    = q.vec_rd;
   assign reg_image_out = q.regs;

endmodule

`default_nettype wire

// ==== testbench/rsc_reset_ctrl_assertions.sv ====
`default_nettype none
module rsc_reset_ctrl_assertions
   import rsc_pkg::*;
#(
   parameter int   STAB_CYCLES = RSC_STAB_CYCLES,
   parameter logic LARGE_ROM   = 1'b1
) (
   input wire logic                              clk_sys_in,
   input wire logic                              rst_in,
   input wire logic                              ext_reset_n_in,
   input wire logic                              watchdog_overflow_in,
   input wire logic                              stop_mode_in,
   input wire logic [7:0]                        vec_data_in,
   input wire rsc_apb_req_s                      apb_req_in,
   input wire rsc_apb_rsp_s                      apb_rsp_out,
   input wire rsc_core_ctl_s                     core_ctl_out,
   input wire logic [15:0]                       pc_out,
   input wire logic                              pc_valid_out,
   input wire logic [15:0]                       vec_addr_out,
   input wire logic                              vec_rd_out,
   input wire logic [RSC_NUM_REGS*RSC_REG_W-1:0] reg_image_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   rsc_core_ctl_s        c;
   logic [RSC_CNT_W-1:0] wait_cnt;
   assign c = core_ctl_out;
   // ****************************************
   // Cycles spent in the stabilization wait
   // ****************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wait_cnt <= '0;
      end else begin
         wait_cnt <= (!c.main_osc_stop && c.pins_hiz && !vec_rd_out) ?
                     wait_cnt + 1'b1 : '0;
      end
   end
   property p_src_ext;
      !ext_reset_n_in [*3] |=> c.main_osc_stop && !pc_valid_out;
   endproperty
   a_src_ext: assert property (p_src_ext)
      else $error("pin reset not taken");
   property p_src_wdt;
      watchdog_overflow_in && reg_image_out[38*8+4] && c.cpu_run
         |=> c.main_osc_stop && c.pins_hiz && !pc_valid_out;
   endproperty
   a_src_wdt: assert property (p_src_wdt)
      else $error("watchdog reset not taken");
   property p_wait;
      $rose(vec_rd_out) |-> wait_cnt == RSC_CNT_W'(STAB_CYCLES);
   endproperty
   a_wait: assert property (p_wait)
      else $error("stabilization wait length wrong");
   property p_vec;
      $rose(vec_rd_out) |-> vec_addr_out == RSC_VEC_LO_ADDR
         ##1 vec_rd_out && vec_addr_out == RSC_VEC_HI_ADDR;
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector fetch order wrong");
   property p_pc;
      $rose(pc_valid_out) |-> c.cpu_run && !c.pins_hiz &&
         pc_out == {$past(vec_data_in), $past(vec_data_in, 2)};
   endproperty
   a_pc: assert property (p_pc)
      else $error("program counter not loaded from vector");
   property p_hiz;
      c.pins_hiz != c.cpu_run;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("pins not tristated while held");
   property p_pcu;
      pc_valid_out == c.cpu_run;
   endproperty
   a_pcu: assert property (p_pcu)
      else $error("program counter valid outside run");
   property p_osc;
      c.main_osc_stop |-> c.sub_osc_run && c.pins_hiz;
   endproperty
   a_osc: assert property (p_osc)
      else $error("subclock stopped in reset");
   property p_stop;
      c.stop_hold |-> c.main_osc_stop && c.pins_hiz;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop contents held outside reset");
   property p_vals;
      c.pins_hiz && !c.main_osc_stop |-> reg_image_out[7:0] == 8'h02 &&
         reg_image_out[87:80] == 8'hff && reg_image_out[175:168] == 8'h04
         && reg_image_out[191:184] == (LARGE_ROM ? 8'hcf : 8'hcc);
   endproperty
   a_vals: assert property (p_vals)
      else $error("reset values not held in wait");
   cover property (c.stop_hold);
   cover property ($rose(pc_valid_out));
   cover property (watchdog_overflow_in && reg_image_out[38*8+4]);
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_assertions #(
   .STAB_CYCLES(STAB_CYCLES), .LARGE_ROM(LARGE_ROM)) u_chk (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .ext_reset_n_in(ext_reset_n_in),
   .watchdog_overflow_in(watchdog_overflow_in),
   .stop_mode_in(stop_mode_in), .vec_data_in(vec_data_in),
   .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out),
   .core_ctl_out(core_ctl_out), .pc_out(pc_out),
   .pc_valid_out(pc_valid_out), .vec_addr_out(vec_addr_out),
   .vec_rd_out(vec_rd_out), .reg_image_out(reg_image_out));
`default_nettype wire

// ==== testbench/rsc_board_reset.sv ====
`default_nettype none
module rsc_board_reset #(
   parameter int HOLD_CYCLES = 2500
) (
   input  wire logic clk_sys_in,
   input  wire logic press_in,
   output logic      ext_reset_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // Pin stays low 10 us past the press at 250 MHz
   always_ff @(posedge clk_sys_in) begin
      if (press_in) begin
         cnt <= HOLD_CYCLES;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign ext_reset_n_out = !(press_in || cnt != 0);
endmodule
`default_nettype wire

// ==== testbench/system_reset_controller_test.sv ====
`default_nettype none
module system_reset_controller_test;
   import rsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 2500;
   logic                              clk_sys_in, rst_in, wdt, stop, press;
   logic                              ext_n, pc_valid, vec_rd, err;
   logic [7:0]                        vec_data;
   logic [15:0]                       pc, vec_addr;
   logic [31:0]                       rd;
   logic [RSC_NUM_REGS*RSC_REG_W-1:0] image;
   rsc_apb_req_s                      req;
   rsc_apb_rsp_s                      rsp;
   rsc_core_ctl_s                     ctl;
   int                                n_fail, check_count, cycles;
   rsc_reset_ctrl #(.STAB_CYCLES(8), .LARGE_ROM(1'b1)) u_dut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ext_reset_n_in(ext_n),
      .watchdog_overflow_in(wdt), .stop_mode_in(stop),
      .vec_data_in(vec_data), .apb_req_in(req), .apb_rsp_out(rsp),
      .core_ctl_out(ctl), .pc_out(pc), .pc_valid_out(pc_valid),
      .vec_addr_out(vec_addr), .vec_rd_out(vec_rd),
      .reg_image_out(image));
   rsc_board_reset #(.HOLD_CYCLES(HOLD)) u_board (
      .clk_sys_in(clk_sys_in), .press_in(press), .ext_reset_n_out(ext_n));
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Vector memory answers one cycle after the address
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         vec_data <= 8'h00;
      end else begin
         vec_data <= vec_rd ? (vec_addr[0] ? 8'h12 : 8'h34) : ~vec_data;
      end
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input int idx, input logic [7:0] d);
      int n;
      req.paddr <= 12'(4 * idx);
      req.pwrite <= wr;
      req.pwdata <= {24'h0, d};
      req.pstrb <= 4'hf;
      req.psel <= 1'b1;
      @(posedge clk_sys_in) req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      chk(n, 1);
      // Idle cycle so the next call does not rewrite psel in this step
      @(posedge clk_sys_in);
   endtask
   task automatic check_reg(input int idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
      chk(err, 0);
   endtask
   task automatic boot();
      while (pc_valid !== 1'b1) begin
         @(posedge clk_sys_in);
      end
      chk(pc, 16'h1234);
      chk(ctl, 7'b0010001);
   endtask
   function automatic logic [7:0] exp_val(input int i);
      if (i == 0 || i == 66) return 8'h02;
      if ((i >= 10 && i <= 18) || i == 49 || (i >= 58 && i <= 63))
         return 8'hff;
      if (i == 21 || i == 24 || i == 29) return 8'h04;
      if (i == 23) return 8'hcf;
      if (i == 39 || i == 40) return 8'h88;
      if (i == 51) return 8'h01;
      return 8'h00;
   endfunction
   task automatic t_values();
      for (int i = 0; i < 78; i++) check_reg(i, exp_val(i));
      apb(1'b0, 79, 8'h00);
      chk({rd[7:0], err}, 9'h001);
      apb(1'b1, 78, 8'h55);
      chk(err, 1);
   endtask
   task automatic t_pin(input logic in_stop, input logic [7:0] cause);
      apb(1'b1, 1, 8'h5a);
      check_reg(1, 8'h5a);
      apb(1'b1, 68, 8'ha5);
      stop <= in_stop;
      press <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      chk(ctl, {5'b11111, in_stop, 1'b0});
      apb(1'b1, 1, 8'h77);
      chk(err, 1);
      press <= 1'b0;
      stop <= 1'b0;
      boot();
      check_reg(1, 8'h00);
      check_reg(68, 8'ha5);
      check_reg(78, cause);
   endtask
   task automatic t_wdt();
      for (int k = 0; k < 2; k++) begin
         if (k == 1) apb(1'b1, 38, 8'h10);
         @(posedge clk_sys_in) wdt <= 1'b1;
         @(posedge clk_sys_in) wdt <= 1'b0;
         repeat (2) @(posedge clk_sys_in);
         chk(ctl.cpu_run, k == 0);
      end
      boot();
      check_reg(78, 8'h02);
      check_reg(38, 8'h00);
   endtask
   initial begin
      rst_in = 1'b1;
      wdt = 1'b0;
      stop = 1'b0;
      press = 1'b0;
      req = '0;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      boot();
      t_values();
      t_pin(1'b0, 8'h01);
      t_pin(1'b1, 8'h05);
      t_wdt();
      print_verdict();
   end
endmodule
`default_nettype wire
